/* hw/burst_read_cfg.svh */
`ifndef BURST_READ_CFG_SVH
`define BURST_READ_CFG_SVH
// Register word offsets (byte addresses)
`define OFS_CONFIG      4'h0
`define OFS_SEED        4'h4
`define OFS_STATUS      4'h8
// Configuration fields
`define CFG_LAT_LSB     0
`define CFG_LAT_MSB     2
`define CFG_FALL_BIT    3
`define CFG_WRAP_BIT    4
`define CFG_LATE_BIT    5
`define CFG_HD_BIT      6
// Reset values
`define CFG_RESET       32'h0000_0007
`define SEED_RESET      16'h0000
// Latency limits and boundary padding
`define LAT_MIN         3'h2
`define LAT_MAX         3'h7
`define PAD_LOW         3'h2
`define PAD_HIGH        3'h3
`define PAD_SPLIT       3'h6
`define BOUNDARY_MASK   6'h3f
`endif

/* hw/burst_read_pkg.sv */
package burst_read_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LAT   = 2'b01,
    ST_DATA  = 2'b10,
    ST_BOUND = 2'b11
  } burst_state_t;
endpackage

/* hw/sync_burst_read_interface.sv */
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "burst_read_cfg.svh"
module sync_burst_read_interface #(
  parameter int ADDR_W = 22
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              burstClk,
  input  wire logic              chipEnableN,
  input  wire logic              address_valid_strobe_n,
  input  wire logic              outputEnableN,
  input  wire logic [ADDR_W-1:0] addrIn,
  output logic [15:0]            dataOut,
  output logic                   dataOe,
  output logic                   ready,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);

  function automatic logic [2:0] clampLat(input logic [2:0] v);
    clampLat = (v < `LAT_MIN) ? `LAT_MIN : v;
  endfunction

  function automatic logic [2:0] padCycles(input logic [2:0] lat,
                                           input logic       hd);
    logic [2:0] base;
    base = (lat >= `PAD_SPLIT) ? `PAD_HIGH : `PAD_LOW;
    padCycles = base + {2'b00, hd};
  endfunction

  // Pin synchronisers
  logic [3:0]        pinS1_r;
  logic [3:0]        pinS2_r;
  logic [1:0]        pinS3_r;
  logic [ADDR_W-1:0] addrS1_r;
  logic [ADDR_W-1:0] addrS2_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinS1_r  <= 4'hf;
      pinS2_r  <= 4'hf;
      pinS3_r  <= 2'h3;
      addrS1_r <= '0;
      addrS2_r <= '0;
    end else begin
      pinS1_r  <= {outputEnableN, address_valid_strobe_n, chipEnableN,
                   burstClk};
      pinS2_r  <= pinS1_r;
      pinS3_r  <= {pinS2_r[2], pinS2_r[0]};
      addrS1_r <= addrIn;
      addrS2_r <= addrS1_r;
    end
  end

  logic clkS;
  logic ceS;
  logic avdS;
  logic oeS;
  assign clkS = pinS2_r[0];
  assign ceS  = pinS2_r[1];
  assign avdS = pinS2_r[2];
  assign oeS  = pinS2_r[3];

  // Configuration registers
  logic [31:0] cfg_r;
  logic [15:0] seed_r;
  logic        wbReq;
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  logic       fallEdge;
  logic       wrapMode;
  logic       lateReady;
  logic       highDensity;
  logic [2:0] cfgLat;
  assign fallEdge    = cfg_r[`CFG_FALL_BIT];
  assign wrapMode    = cfg_r[`CFG_WRAP_BIT];
  assign lateReady   = cfg_r[`CFG_LATE_BIT];
  assign highDensity = cfg_r[`CFG_HD_BIT];
  assign cfgLat      = clampLat(cfg_r[`CFG_LAT_MSB:`CFG_LAT_LSB]);

  // Active edge and address capture events
  logic actEdge;
  logic avdRise;
  logic avdFall;
  assign actEdge = fallEdge ? (pinS3_r[0] & ~clkS)
                            : (~pinS3_r[0] & clkS);
  assign avdRise = ~pinS3_r[1] & avdS;
  assign avdFall = pinS3_r[1] & ~avdS;

  logic pending_r;
  logic capEv;
  assign capEv = pending_r & ~ceS & ((actEdge & ~avdS) | avdRise);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pending_r <= 1'b0;
    end else if (ceS) begin
      pending_r <= 1'b0;
    end else if (avdFall) begin
      pending_r <= 1'b1;
    end else if (capEv) begin
      pending_r <= 1'b0;
    end
  end

  // Burst engine
  burst_read_pkg::burst_state_t state_r;
  logic [ADDR_W-1:0] burstAddr_r;
  logic [2:0]        cnt_r;
  logic [2:0]        lat_r;
  logic              vAhead_r;
  logic              dValid_r;
  logic [ADDR_W-1:0] nextAddr;

  always_comb begin
    nextAddr = burstAddr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
    if (wrapMode) begin
      nextAddr[2:0] = burstAddr_r[2:0] + 3'h1;
      nextAddr[ADDR_W-1:3] = burstAddr_r[ADDR_W-1:3];
    end
  end

  // Look-ahead of the valid flag, so early ready leads the data
  logic atBound;
  logic vAheadNxt;
  assign atBound = !wrapMode
                   && ((nextAddr[5:0] & `BOUNDARY_MASK) == 6'h00);

  always_comb begin
    vAheadNxt = vAhead_r;
    if (ceS || capEv) begin
      vAheadNxt = 1'b0;
    end else if (actEdge) begin
      case (state_r)
        burst_read_pkg::ST_LAT:   vAheadNxt = (cnt_r == 3'h0);
        burst_read_pkg::ST_DATA:  vAheadNxt = ~atBound;
        burst_read_pkg::ST_BOUND: vAheadNxt = (cnt_r == 3'h0);
        default:                  vAheadNxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r     <= burst_read_pkg::ST_IDLE;
      burstAddr_r <= '0;
      cnt_r       <= 3'h0;
      lat_r       <= `LAT_MIN;
      vAhead_r    <= 1'b0;
    end else if (ceS) begin
      state_r  <= burst_read_pkg::ST_IDLE;
      vAhead_r <= 1'b0;
    end else if (capEv) begin
      state_r     <= burst_read_pkg::ST_LAT;
      burstAddr_r <= addrS2_r;
      lat_r       <= cfgLat;
      cnt_r       <= cfgLat - `LAT_MIN;
      vAhead_r    <= 1'b0;
    end else if (actEdge) begin
      case (state_r)
        burst_read_pkg::ST_LAT: begin
          if (cnt_r == 3'h0) begin
            state_r  <= burst_read_pkg::ST_DATA;
            vAhead_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        burst_read_pkg::ST_DATA: begin
          burstAddr_r <= nextAddr;
          if (atBound) begin
            state_r  <= burst_read_pkg::ST_BOUND;
            cnt_r    <= padCycles(lat_r, highDensity) - 3'h1;
            vAhead_r <= 1'b0;
          end else begin
            vAhead_r <= 1'b1;
          end
        end
        burst_read_pkg::ST_BOUND: begin
          if (cnt_r == 3'h0) begin
            state_r  <= burst_read_pkg::ST_DATA;
            vAhead_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: begin
          vAhead_r <= 1'b0;
        end
      endcase
    end
  end

  // Output stage: data one edge behind the look-ahead valid
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dValid_r <= 1'b0;
      ready    <= 1'b0;
      dataOut  <= 16'h0000;
    end else if (ceS) begin
      dValid_r <= 1'b0;
      ready    <= 1'b0;
    end else if (actEdge) begin
      dValid_r <= vAhead_r;
      dataOut  <= burstAddr_r[15:0] ^ seed_r;
      ready    <= lateReady ? vAhead_r : vAheadNxt;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dataOe <= 1'b0;
    end else begin
      dataOe <= ~ceS & ~oeS;
    end
  end

  // Wishbone slave
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg_r    <= `CFG_RESET;
      seed_r   <= `SEED_RESET;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && wb_we_i) begin
        case (wb_adr_i)
          `OFS_CONFIG: begin
            if (wb_sel_i[0]) begin
              cfg_r[7:0] <= wb_dat_i[7:0];
            end
          end
          `OFS_SEED: begin
            if (wb_sel_i[0]) begin
              seed_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              seed_r[15:8] <= wb_dat_i[15:8];
            end
          end
          default: begin
          end
        endcase
      end
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_CONFIG: wb_dat_o <= {24'h00_0000, cfg_r[7:0]};
          `OFS_SEED:   wb_dat_o <= {16'h0000, seed_r};
          `OFS_STATUS: wb_dat_o <= {6'h00, state_r, dValid_r,
                                    {(23-ADDR_W){1'b0}}, burstAddr_r};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Helper counters for checks
  logic [3:0] edgeCnt_r;
  logic [2:0] gap_r;
  logic       firstPend_r;
  logic       inBound;
  assign inBound = (state_r == burst_read_pkg::ST_BOUND);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      edgeCnt_r   <= 4'h0;
      gap_r       <= 3'h0;
      firstPend_r <= 1'b0;
    end else begin
      if (capEv) begin
        edgeCnt_r   <= 4'h0;
        firstPend_r <= 1'b1;
      end else if (actEdge && edgeCnt_r != 4'hf) begin
        edgeCnt_r <= edgeCnt_r + 4'h1;
      end
      if (dValid_r) begin
        firstPend_r <= 1'b0;
      end
      if (!inBound) begin
        gap_r <= 3'h0;
      end else if (actEdge) begin
        gap_r <= gap_r + 3'h1;
      end
    end
  end

  addr_capture_a: assert property (@(posedge clock) disable iff (!nrst)
    capEv && !ceS |=> burstAddr_r == $past(addrS2_r))
    else $error("burst address not captured");

  init_latency_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(dValid_r) && firstPend_r |-> edgeCnt_r == {1'b0, lat_r})
    else $error("initial latency count wrong");

  boundary_pad_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(inBound) && !ceS && !highDensity
      |-> gap_r == padCycles(lat_r, 1'b0))
    else $error("boundary padding count wrong");

  active_edge_a: assert property (@(posedge clock) disable iff (!nrst)
    !actEdge && !ceS && !capEv |=> $stable(dValid_r) && $stable(ready))
    else $error("output moved off active edge");

  wrap_range_a: assert property (@(posedge clock) disable iff (!nrst)
    wrapMode && state_r == burst_read_pkg::ST_DATA && actEdge && !ceS
      && !capEv
      |=> burstAddr_r[ADDR_W-1:3] == $past(burstAddr_r[ADDR_W-1:3])
        && burstAddr_r[2:0] == $past(burstAddr_r[2:0]) + 3'h1)
    else $error("wrap burst left aligned range");

  early_ready_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(dValid_r) && !lateReady && $stable(lateReady) |-> $past(ready))
    else $error("ready not ahead of data");

  dense_pad_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(inBound) && !ceS && highDensity
      |-> gap_r == padCycles(lat_r, 1'b1))
    else $error("dense boundary padding wrong");

endmodule

/* verification/host_burst_model.sv */
`timescale 1ns/1ps
module host_burst_model (
  input  wire logic        clock,
  input  wire logic        fallEdge,
  input  wire logic [15:0] dataOut,
  input  wire logic        ready,
  output logic             burstClk,
  output logic             chipEnableN,
  output logic             address_valid_strobe_n,
  output logic             outputEnableN,
  output logic [21:0]      addrIn
);
  initial begin
    burstClk = 1'b0;
    chipEnableN = 1'b1;
    address_valid_strobe_n = 1'b1;
    outputEnableN = 1'b1;
    addrIn = 22'h00_0000;
  end
  // A phase spans four system clocks so the pin synchronisers see it
  task automatic phase(input logic lvl);
    burstClk <= lvl;
    repeat (4) @(posedge clock);
  endtask
  // One active edge, answer taken once settled
  task automatic tick(output logic rdy, output logic [15:0] d);
    phase(!fallEdge);
    phase(fallEdge);
    rdy = ready;
    d = dataOut;
  endtask
  // Capture by clock edge, or by strobe rise before any active edge
  task automatic start(input logic [21:0] a, input logic byStrobe);
    logic        r;
    logic [15:0] d;
    chipEnableN <= 1'b0;
    outputEnableN <= 1'b0;
    address_valid_strobe_n <= 1'b0;
    addrIn <= a;
    phase(fallEdge);
    if (!byStrobe) begin
      tick(r, d);
    end
    address_valid_strobe_n <= 1'b1;
    // Address held past the strobe rise, then scrambled
    phase(fallEdge);
    addrIn <= ~a;
  endtask
  task automatic stop();
    chipEnableN <= 1'b1;
    outputEnableN <= 1'b1;
    phase(fallEdge);
  endtask
endmodule

/* verification/sync_burst_read_interface_test.sv */
`timescale 1ns/1ps
module sync_burst_read_interface_test;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        fallEdge = 1'b0;
  logic        burstClk, chipEnableN, address_valid_strobe_n, outputEnableN;
  logic [21:0] addrIn;
  logic [15:0] dataOut;
  logic [15:0] seed = 16'h0000;
  logic        dataOe, ready, wb_ack_o;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  int          failures = 0;
  int          tests_run = 0;
  logic [7:0]  bnd [5] = '{8'h22, 8'h05, 8'h26, 8'h62, 8'h67};

  always #12.5 clock = ~clock;

  sync_burst_read_interface dut (
    .clock(clock), .nrst(nrst), .burstClk(burstClk),
    .chipEnableN(chipEnableN),
    .address_valid_strobe_n(address_valid_strobe_n),
    .outputEnableN(outputEnableN), .addrIn(addrIn), .dataOut(dataOut),
    .dataOe(dataOe), .ready(ready), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  host_burst_model host (
    .clock(clock), .fallEdge(fallEdge), .dataOut(dataOut), .ready(ready),
    .burstClk(burstClk), .chipEnableN(chipEnableN),
    .address_valid_strobe_n(address_valid_strobe_n),
    .outputEnableN(outputEnableN), .addrIn(addrIn));

  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    // Wait for the acknowledge; the watchdog ends this wait only if none comes
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  // Expected ready and words follow from latency, padding and wrap
  task automatic burst(input logic [7:0] cfg, input logic [21:0] a,
                       input int n, input logic byStrobe);
    logic        r;
    logic        v;
    logic [15:0] d;
    logic [31:0] rd;
    int          w;
    int          pad;
    fallEdge <= cfg[3];
    wb(1'b1, 4'h0, {24'h00_0000, cfg}, rd);
    pad = (cfg[2:0] >= 3'h6 ? 3 : 2) + int'(cfg[6]);
    w = cfg[2:0] < 3'h2 ? 2 : int'(cfg[2:0]);
    host.start(a, byStrobe);
    check(32'(dataOe), 32'h0000_0001);
    while (n > 0) begin
      host.tick(r, d);
      w--;
      v = (w == 0);
      if (v) begin
        check(32'(d), 32'(a[15:0] ^ seed));
        n--;
        w = 1;
        a = cfg[4] ? {a[21:3], a[2:0] + 3'h1} : a + 22'h1;
        if (!cfg[4] && a[5:0] == 6'h00) w = pad + 1;
      end
      check(32'(r), 32'(cfg[5] ? v : w == 1));
    end
    host.stop();
    check(32'(dataOe), 32'h0000_0000);
    $display("burst cfg=%h done", cfg);
  endtask

  initial begin
    logic [31:0] rd;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    wb(1'b0, 4'h0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0007);
    wb(1'b1, 4'hc, 32'hffff_ffff, rd);
    wb(1'b0, 4'hc, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wb(1'b1, 4'h4, 32'h0000_a5c3, rd);
    wb(1'b0, 4'h4, 32'h0000_0000, rd);
    check(rd, 32'h0000_a5c3);
    // Power-up style hardware reset, 50 us at 25 ns per clock
    nrst <= 1'b0;
    repeat (2000) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    wb(1'b0, 4'h4, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wb(1'b0, 4'h8, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wb(1'b0, 4'h0, 32'h0000_0000, rd);
    check(rd, 32'h0000_0007);
    wb(1'b1, 4'h4, 32'h0000_a5c3, rd);
    seed = 16'ha5c3;
    $display("registers done");
    for (int l = 2; l <= 7; l++) begin
      burst({5'h04, 3'(l)}, 22'h00_1230, 3, 1'b0);
    end
    burst(8'h03, 22'h00_0100, 4, 1'b0);
    burst(8'h2a, 22'h00_0150, 3, 1'b0);
    burst(8'h24, 22'h00_0200, 3, 1'b1);
    burst(8'h33, 22'h00_0405, 10, 1'b0);
    foreach (bnd[i]) begin
      burst(bnd[i], 22'h00_003e, 4, 1'b0);
    end
    end_sim;
  end

  // Long reset and bursts need about 3300 clocks; ample margin
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim;
  end
endmodule
